// file: hw/fec_top.sv
// fast event counter with special functions, AXI4-Lite slave
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fec_defs.svh"
module fec_top #(
  parameter int TICK_CYCLES = `FEC_TICK_NS / `FEC_CLK_NS,
  parameter int WDOG_TICKS = `FEC_WDOG_TICKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins
  input wire logic cnt_pulse,
  input wire logic preset_in,
  input wire logic [1:0] cap_in,
  input wire logic [7:0] in_pins,
  output logic [7:0] out_pins,
  output logic contact_out,
  output logic cyc_out,
  output logic irq
);
  initial begin
    if (TICK_CYCLES < 1 || WDOG_TICKS < 1 || WDOG_TICKS > 65535) begin
      $error("fec_top: bad parameter");
    end
  end
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [11:0] sync1, sync2;
  logic cnt_prev;
  logic [1:0] cap_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      cnt_prev <= 1'b0;
      cap_prev <= '0;
    end else begin
      sync1 <= {in_pins, cap_in, preset_in, cnt_pulse};
      sync2 <= sync1;
      cnt_prev <= sync2[0];
      cap_prev <= sync2[3:2];
    end
  end
  logic pulse_edge, preset_lvl;
  logic [1:0] cap_edge;
  // at most one edge per two clocks; a 2 kHz input leaves ample margin
  assign pulse_edge = sync2[0] & ~cnt_prev;
  assign preset_lvl = sync2[1];
  assign cap_edge = sync2[3:2] & ~cap_prev;
  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_have, w_have, do_wr, next_aw_have, next_w_have, next_bvalid;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  assign do_wr = aw_have & w_have & ~bvalid;
  assign next_aw_have = (aw_have | (awvalid & awready)) & ~do_wr;
  assign next_w_have = (w_have | (wvalid & wready)) & ~do_wr;
  assign next_bvalid = do_wr | (bvalid & ~bready);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i+:8] = nw[8*i+:8];
      end
    end
    return r;
  endfunction
  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `FEC_A_SCAN;
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `FEC_RESP_OKAY;
      wa <= '0;
      wd <= '0;
      ws <= '0;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      awready <= ~next_aw_have;
      wready <= ~next_w_have;
      bvalid <= next_bvalid;
      if (awvalid && awready) begin
        wa <= awaddr;
      end
      if (wvalid && wready) begin
        wd <= wdata;
        ws <= wstrb;
      end
      if (do_wr) begin
        bresp <= mapped(wa) ? `FEC_RESP_OKAY : `FEC_RESP_SLVERR;
      end
    end
  end
  logic wr_ctrl, wr_stat, wr_sf, wr_scan;
  assign wr_ctrl = do_wr && wa == `FEC_A_CTRL;
  assign wr_stat = do_wr && wa == `FEC_A_STATUS && ws[0];
  assign wr_sf = do_wr && wa == `FEC_A_SFUNC && ws[0];
  assign wr_scan = do_wr && wa == `FEC_A_SCAN;
  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [`FEC_CTRL_W-1:0] ctrl;
  logic [19:0] preset, cmp0, cmp1;
  logic [`FEC_ST_W-1:0] mask;
  logic [7:0] out_img;
  logic [31:0] timer_cfg;
  logic [31:0] mrg;
  assign mrg = merge(32'h0, wd, ws);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '0;
      preset <= '0;
      cmp0 <= `FEC_CNT_MAX;
      cmp1 <= `FEC_CNT_MAX;
      mask <= '0;
      out_img <= '0;
      timer_cfg <= '0;
    end else if (do_wr) begin
      case (wa)
        `FEC_A_CTRL: ctrl <= `FEC_CTRL_W'(merge(32'(ctrl), wd, ws));
        `FEC_A_PRESET: preset <= 20'(merge(32'(preset), wd, ws));
        `FEC_A_CMP0: cmp0 <= 20'(merge(32'(cmp0), wd, ws));
        `FEC_A_CMP1: cmp1 <= 20'(merge(32'(cmp1), wd, ws));
        `FEC_A_MASK: mask <= `FEC_ST_W'(merge(32'(mask), wd, ws));
        `FEC_A_OUTIMG: out_img <= 8'(merge(32'(out_img), wd, ws));
        `FEC_A_TIMER: timer_cfg <= merge(timer_cfg, wd, ws);
        default: ;
      endcase
    end
  end
  logic sf_go;
  logic [7:0] sf_code;
  assign sf_go = wr_sf;
  assign sf_code = mrg[7:0];
  // ----------------------------------------
  // fast counter
  // ----------------------------------------
  logic [19:0] cnt, next_cnt;
  logic step, up, at_end, wrap, reload_pend, hold;
  logic match0, match1, match_any;
  // fast path counts pin edges, normal mode counts writes to the scan register
  assign step = ctrl[`FEC_C_FAST] ? pulse_edge : wr_scan;
  assign up = ctrl[`FEC_C_UP];
  assign at_end = up ? (cnt >= `FEC_CNT_MAX) : (cnt == 20'h0);
  always_comb begin
    if (up) begin
      next_cnt = at_end ? 20'h0 : cnt + 20'h1;
    end else begin
      next_cnt = at_end ? `FEC_CNT_MAX : cnt - 20'h1;
    end
  end
  assign hold = preset_lvl | reload_pend;
  assign wrap = step & ~hold & at_end;
  assign match0 = step & ~hold & (next_cnt == cmp0);
  assign match1 = step & ~hold & (next_cnt == cmp1);
  assign match_any = match0 | match1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 20'h0;
      reload_pend <= 1'b0;
    end else begin
      reload_pend <= match_any & ctrl[`FEC_C_AUTO];
      if (preset_lvl || reload_pend) begin
        cnt <= preset;
      end else if (step) begin
        cnt <= next_cnt;
      end
    end
  end
  // ----------------------------------------
  // status, flags, outputs
  // ----------------------------------------
  logic [`FEC_ST_W-1:0] status, st_set, st_clr;
  logic [2:0] flags;
  logic contact, contact_img, tick, wdog_to;
  logic [7:0] in_img;
  logic [15:0] wdog_cnt;
  logic [31:0] tick_cnt;
  assign st_set = {wdog_to, cap_edge, wrap, match1, match0};
  assign st_clr = (wr_stat ? mrg[`FEC_ST_W-1:0] : '0)
                | ((sf_go && sf_code == `FEC_SF_CLR_FULL) ? `FEC_ST_W'(4) : '0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~st_clr) | st_set;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else if (sf_go) begin
      case (sf_code)
        `FEC_SF_SET_CARRY: flags[`FEC_F_CARRY] <= 1'b1;
        `FEC_SF_CLR_CARRY: flags[`FEC_F_CARRY] <= 1'b0;
        `FEC_SF_SET_ZERO: flags[`FEC_F_ZERO] <= 1'b1;
        `FEC_SF_CLR_ZERO: flags[`FEC_F_ZERO] <= 1'b0;
        `FEC_SF_SET_BORROW: flags[`FEC_F_BORROW] <= 1'b1;
        `FEC_SF_CLR_BORROW: flags[`FEC_F_BORROW] <= 1'b0;
        default: ;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      contact <= 1'b0;
      contact_img <= 1'b0;
      contact_out <= 1'b0;
      out_pins <= '0;
      in_img <= '0;
      irq <= 1'b0;
    end else begin
      if (match_any) begin
        contact <= 1'b1;
      end else if (sf_go && sf_code == `FEC_SF_CLR_CONTACT) begin
        contact <= 1'b0;
      end
      if (sf_go && sf_code == `FEC_SF_OUT_REFRESH) begin
        out_pins <= out_img;
        contact_img <= contact;
      end
      if (sf_go && sf_code == `FEC_SF_IN_REFRESH) begin
        in_img <= sync2[11:4];
      end
      contact_out <= ctrl[`FEC_C_DIRECT] ? contact : contact_img;
      irq <= |(status & mask);
    end
  end
  // ----------------------------------------
  // tenth-second tick, watchdog, cyclic timer
  // ----------------------------------------
  assign tick = tick_cnt == 32'(TICK_CYCLES - 1);
  assign wdog_to = tick && wdog_cnt == 16'(WDOG_TICKS - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= '0;
      wdog_cnt <= '0;
    end else begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
      if (sf_go && sf_code == `FEC_SF_WDOG) begin
        wdog_cnt <= 16'h0;
      end else if (tick && wdog_cnt != 16'(WDOG_TICKS)) begin
        wdog_cnt <= wdog_cnt + 16'h1;
      end
    end
  end
  fec_cyc_timer #(
    .W(16)
  ) u_cyc (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .run(ctrl[`FEC_C_CYC]),
    .on_ticks(timer_cfg[15:0]),
    .off_ticks(timer_cfg[31:16]),
    .cyc_out(cyc_out)
  );
  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [31:0] rmux;
  always_comb begin
    case (araddr)
      `FEC_A_CTRL: rmux = 32'(ctrl);
      `FEC_A_PRESET: rmux = 32'(preset);
      `FEC_A_CMP0: rmux = 32'(cmp0);
      `FEC_A_CMP1: rmux = 32'(cmp1);
      `FEC_A_COUNT: rmux = 32'(cnt);
      `FEC_A_STATUS: rmux = 32'(status);
      `FEC_A_MASK: rmux = 32'(mask);
      `FEC_A_SFUNC: rmux = 32'({contact, flags});
      `FEC_A_INIMG: rmux = 32'(in_img);
      `FEC_A_OUTIMG: rmux = 32'(out_img);
      `FEC_A_TIMER: rmux = timer_cfg;
      default: rmux = 32'h0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `FEC_RESP_OKAY;
    end else begin
      arready <= ~((rvalid & ~rready) | (arvalid & arready));
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rmux;
        rresp <= mapped(araddr) ? `FEC_RESP_OKAY : `FEC_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_hit_auto;
    match_any && ctrl[`FEC_C_AUTO];
  endsequence
  sequence s_reloaded;
    cnt == $past(preset);
  endsequence
  chk_count_range: assert property (cnt <= `FEC_CNT_MAX)
    else $error("count above maximum");
  chk_up_step: assert property (step && !hold && up && !at_end |=>
    cnt == $past(cnt) + 20'h1) else $error("up step wrong");
  chk_down_wrap: assert property (step && !hold && !up && cnt == 20'h0 |=>
    cnt == `FEC_CNT_MAX && status[`FEC_S_FULL]) else $error("underflow wrong");
  chk_preset_load: assert property (preset_lvl |=> s_reloaded)
    else $error("preset not loaded");
  chk_auto_reload: assert property (s_hit_auto ##1 !preset_lvl |=> s_reloaded)
    else $error("auto reload missing");
  chk_match_irq: assert property (match0 && mask[`FEC_S_MATCH0] |-> ##2 irq)
    else $error("match irq missing");
  chk_direct_out: assert property (match_any ##1 ctrl[`FEC_C_DIRECT] |=> contact_out)
    else $error("direct output late");
  chk_capture_hold: assert property (cap_edge[0] ##1 !(wr_stat && mrg[`FEC_S_CAP0])
    |-> status[`FEC_S_CAP0]) else $error("capture lost");
  chk_code_ten: assert property (sf_go && sf_code == `FEC_SF_CLR_FULL && !wrap
    |=> !status[`FEC_S_FULL]) else $error("full flag not cleared");
  chk_code_eleven: assert property (sf_go && sf_code == `FEC_SF_CLR_CONTACT && !match_any
    |=> !contact) else $error("contact not cleared");
  chk_carry_set: assert property (sf_go && sf_code == `FEC_SF_SET_CARRY
    |=> flags[`FEC_F_CARRY]) else $error("carry not set");
  chk_wdog_restart: assert property (sf_go && sf_code == `FEC_SF_WDOG
    |=> wdog_cnt == 16'h0 && !status[`FEC_S_WDOG] || $past(status[`FEC_S_WDOG]))
    else $error("watchdog not restarted");
  chk_out_refresh: assert property (sf_go && sf_code == `FEC_SF_OUT_REFRESH
    |=> out_pins == $past(out_img)) else $error("outputs not refreshed");
endmodule

// file: hw/fec_defs.svh
// constants of the fast event counter
`ifndef FEC_DEFS_SVH
`define FEC_DEFS_SVH
// ----------------------------------------
// count range and timing
// ----------------------------------------
`define FEC_CNT_MAX 20'hF423F
`define FEC_CLK_NS 10
`define FEC_TICK_NS 100000000
`define FEC_WDOG_TICKS 10
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FEC_A_CTRL 8'h00
`define FEC_A_PRESET 8'h04
`define FEC_A_CMP0 8'h08
`define FEC_A_CMP1 8'h0C
`define FEC_A_COUNT 8'h10
`define FEC_A_STATUS 8'h14
`define FEC_A_MASK 8'h18
`define FEC_A_SFUNC 8'h1C
`define FEC_A_INIMG 8'h20
`define FEC_A_OUTIMG 8'h24
`define FEC_A_TIMER 8'h28
`define FEC_A_SCAN 8'h2C
// ----------------------------------------
// control bits
// ----------------------------------------
`define FEC_C_FAST 0
`define FEC_C_UP 1
`define FEC_C_AUTO 2
`define FEC_C_DIRECT 3
`define FEC_C_CYC 4
`define FEC_CTRL_W 5
// ----------------------------------------
// status bits
// ----------------------------------------
`define FEC_S_MATCH0 0
`define FEC_S_MATCH1 1
`define FEC_S_FULL 2
`define FEC_S_CAP0 3
`define FEC_S_CAP1 4
`define FEC_S_WDOG 5
`define FEC_ST_W 6
// ----------------------------------------
// special function codes and flag bits
// ----------------------------------------
`define FEC_SF_IN_REFRESH 8'h00
`define FEC_SF_OUT_REFRESH 8'h02
`define FEC_SF_WDOG 8'h04
`define FEC_SF_CLR_FULL 8'h0A
`define FEC_SF_CLR_CONTACT 8'h0B
`define FEC_SF_SET_CARRY 8'h0E
`define FEC_SF_CLR_CARRY 8'h0F
`define FEC_SF_SET_ZERO 8'h10
`define FEC_SF_CLR_ZERO 8'h11
`define FEC_SF_SET_BORROW 8'h12
`define FEC_SF_CLR_BORROW 8'h13
`define FEC_F_CARRY 0
`define FEC_F_ZERO 1
`define FEC_F_BORROW 2
`define FEC_F_CONTACT 3
`define FEC_RESP_OKAY 2'h0
`define FEC_RESP_SLVERR 2'h2
`endif

// file: hw/fec_pkg.sv
// types of the fast event counter
package fec_pkg;
  typedef enum logic [2:0] {
    FEC_CT_IDLE = 3'h1,
    FEC_CT_ON = 3'h2,
    FEC_CT_OFF = 3'h4
  } fec_ct_state_t;
endpackage

// file: hw/fec_cyc_timer.sv
// cyclic on/off timer stepped by the tenth-second tick
`timescale 1ns/1ps
`include "fec_defs.svh"
module fec_cyc_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] on_ticks,
  input wire logic [W-1:0] off_ticks,
  // output
  output logic cyc_out
);
  initial begin
    if (W < 1 || W > 16) begin
      $error("fec_cyc_timer: W out of range");
    end
  end
  fec_pkg::fec_ct_state_t state;
  logic [W-1:0] left;
  // zero periods act as one tick, the shortest period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= fec_pkg::FEC_CT_IDLE;
      left <= '0;
      cyc_out <= 1'b0;
    end else if (!run) begin
      state <= fec_pkg::FEC_CT_IDLE;
      cyc_out <= 1'b0;
    end else begin
      case (state)
        fec_pkg::FEC_CT_IDLE: begin
          state <= fec_pkg::FEC_CT_ON;
          left <= on_ticks;
          cyc_out <= 1'b1;
        end
        fec_pkg::FEC_CT_ON: begin
          if (tick) begin
            if (left <= W'(1)) begin
              state <= fec_pkg::FEC_CT_OFF;
              left <= off_ticks;
              cyc_out <= 1'b0;
            end else begin
              left <= left - W'(1);
            end
          end
        end
        fec_pkg::FEC_CT_OFF: begin
          if (tick) begin
            if (left <= W'(1)) begin
              state <= fec_pkg::FEC_CT_ON;
              left <= on_ticks;
              cyc_out <= 1'b1;
            end else begin
              left <= left - W'(1);
            end
          end
        end
        default: begin
          state <= fec_pkg::FEC_CT_IDLE;
        end
      endcase
    end
  end
endmodule

// file: tb/fec_pulse_src.sv
// model of the external pulse sensor and the two capture contacts
`timescale 1ns/1ps
module fec_pulse_src (
  // clock
  input wire logic aclk,
  // sensor pins
  output logic cnt_pulse,
  output logic [1:0] cap_in
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    cnt_pulse = 1'b0;
    cap_in = 2'h0;
  end
  // ----------------------------------------
  // pulse trains
  // ----------------------------------------
  // single-phase train, high and low long enough for the pin filter
  task automatic send(input int k);
    repeat (k) begin
      @(posedge aclk);
      cnt_pulse <= 1'b1;
      repeat (4) @(posedge aclk);
      cnt_pulse <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
  // momentary pulse, far shorter than a program scan
  task automatic capture(input int ch);
    @(posedge aclk);
    cap_in[ch] <= 1'b1;
    repeat (3) @(posedge aclk);
    cap_in[ch] <= 1'b0;
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench of the fast event counter
`timescale 1ns/1ps
`include "fec_defs.svh"
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [31:0] ALL_BITS = 32'hFFFF_FFFF;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr, in_pins;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, preset_in;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, cap_in;
  logic [31:0] rdata;
  logic cnt_pulse, contact_out, cyc_out, irq;
  logic [7:0] out_pins;
  logic [31:0] rv;
  logic [1:0] rs;
  int fail_count = 0;
  int num_checks = 0;
  int n;

  always #5 aclk = ~aclk;

  fec_top #(.TICK_CYCLES(10), .WDOG_TICKS(3)) fec_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cnt_pulse(cnt_pulse), .preset_in(preset_in), .cap_in(cap_in), .in_pins(in_pins),
    .out_pins(out_pins), .contact_out(contact_out), .cyc_out(cyc_out), .irq(irq)
  );

  fec_pulse_src fec_pulse_src_i (.aclk(aclk), .cnt_pulse(cnt_pulse), .cap_in(cap_in));

  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    fail_count++;
    $display("[FAIL] t=%0t handshake timeout", $time);
    complete_run();
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    rd(a);
    chk(rv & m, exp);
  endtask

  task automatic preset_pulse();
    preset_in <= 1'b1;
    idle(5);
    preset_in <= 1'b0;
    idle(5);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    awaddr <= 8'h00;
    araddr <= 8'h00;
    in_pins <= 8'h00;
    wdata <= 32'h0000_0000;
    wstrb <= 4'hF;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    preset_in <= 1'b0;
    idle(10);
    aresetn <= 1'b1;
    rdchk(`FEC_A_CMP1, 32'h000F_423F, ALL_BITS);
    rdchk(`FEC_A_COUNT, 32'h0000_0000, ALL_BITS);
    rdchk(`FEC_A_STATUS, 32'h0000_0000, ALL_BITS);
    rd(8'h30);
    chk(rs, `FEC_RESP_SLVERR);
    chk(rv, 32'h0000_0000);
    wr(8'h30, 32'h0000_0001);
    chk(rs, `FEC_RESP_SLVERR);
    $display("reset and map test done");

    wr(`FEC_A_CTRL, 32'h0000_0003);
    fec_pulse_src_i.send(5);
    rdchk(`FEC_A_COUNT, 32'h0000_0005, ALL_BITS);
    wr(`FEC_A_CTRL, 32'h0000_0001);
    fec_pulse_src_i.send(6);
    rdchk(`FEC_A_COUNT, 32'h000F_423F, ALL_BITS);
    rdchk(`FEC_A_STATUS, 32'h0000_0004, 32'h0000_0004);
    wr(`FEC_A_SFUNC, `FEC_SF_CLR_FULL);
    rdchk(`FEC_A_STATUS, 32'h0000_0000, 32'h0000_0004);
    $display("count and wrap test done");

    wr(`FEC_A_PRESET, 32'h000F_423E);
    wr(`FEC_A_CTRL, 32'h0000_0003);
    preset_pulse();
    rdchk(`FEC_A_COUNT, 32'h000F_423E, ALL_BITS);
    fec_pulse_src_i.send(2);
    rdchk(`FEC_A_COUNT, 32'h0000_0000, ALL_BITS);
    rdchk(`FEC_A_STATUS, 32'h0000_0004, 32'h0000_0004);
    wr(`FEC_A_STATUS, 32'h0000_003F);
    rdchk(`FEC_A_STATUS, 32'h0000_0000, ALL_BITS);
    $display("preset test done");

    wr(`FEC_A_MASK, 32'h0000_0001);
    wr(`FEC_A_CMP0, 32'h0000_0002);
    fec_pulse_src_i.send(2);
    rdchk(`FEC_A_STATUS, 32'h0000_0001, 32'h0000_0001);
    idle(2);
    chk(irq, 1'b1);
    wr(`FEC_A_MASK, 32'h0000_0000);
    idle(2);
    chk(irq, 1'b0);
    wr(`FEC_A_MASK, 32'h0000_0001);
    idle(2);
    chk(irq, 1'b1);
    wr(`FEC_A_STATUS, 32'h0000_0001);
    idle(2);
    chk(irq, 1'b0);
    $display("match interrupt test done");

    wr(`FEC_A_PRESET, 32'h0000_000A);
    wr(`FEC_A_CMP0, 32'h0000_000C);
    wr(`FEC_A_SFUNC, `FEC_SF_CLR_CONTACT);
    wr(`FEC_A_CTRL, 32'h0000_000F);
    preset_pulse();
    chk(contact_out, 1'b0);
    fec_pulse_src_i.send(2);
    rdchk(`FEC_A_COUNT, 32'h0000_000A, ALL_BITS);
    chk(contact_out, 1'b1);
    wr(`FEC_A_SFUNC, `FEC_SF_CLR_CONTACT);
    idle(2);
    chk(contact_out, 1'b0);
    $display("reload and direct output test done");

    wr(`FEC_A_CTRL, 32'h0000_0002);
    fec_pulse_src_i.send(1);
    rdchk(`FEC_A_COUNT, 32'h0000_000A, ALL_BITS);
    wr(`FEC_A_SCAN, 32'h0000_0000);
    wr(`FEC_A_SCAN, 32'h0000_0000);
    rdchk(`FEC_A_COUNT, 32'h0000_000C, ALL_BITS);
    $display("normal counter test done");

    fec_pulse_src_i.capture(0);
    fec_pulse_src_i.capture(1);
    idle(4);
    rdchk(`FEC_A_STATUS, 32'h0000_0018, 32'h0000_0018);
    wr(`FEC_A_STATUS, 32'h0000_0018);
    rdchk(`FEC_A_STATUS, 32'h0000_0000, 32'h0000_0018);
    $display("capture test done");

    // set then clear carry, zero, borrow in turn
    for (n = 0; n < 6; n++) begin
      wr(`FEC_A_SFUNC, 32'h0000_000E + n);
      rdchk(`FEC_A_SFUNC, (n % 2) ? 32'h0 : (32'h1 << (n / 2)), 32'h0000_0007);
    end
    $display("flag code test done");

    in_pins <= 8'hA5;
    wr(`FEC_A_SFUNC, `FEC_SF_IN_REFRESH);
    rdchk(`FEC_A_INIMG, 32'h0000_00A5, 32'h0000_00FF);
    wr(`FEC_A_OUTIMG, 32'h0000_003C);
    idle(2);
    chk(out_pins, 8'h00);
    wr(`FEC_A_SFUNC, `FEC_SF_OUT_REFRESH);
    idle(2);
    chk(out_pins, 8'h3C);
    wstrb <= 4'h1;
    wr(`FEC_A_PRESET, 32'h000F_42FF);
    wstrb <= 4'hF;
    rdchk(`FEC_A_PRESET, 32'h0000_00FF, ALL_BITS);
    $display("refresh test done");

    // watchdog expired long ago; restart holds it off for a while
    wr(`FEC_A_STATUS, 32'h0000_0020);
    wr(`FEC_A_SFUNC, `FEC_SF_WDOG);
    rdchk(`FEC_A_STATUS, 32'h0000_0000, 32'h0000_0020);
    idle(40);
    rdchk(`FEC_A_STATUS, 32'h0000_0020, 32'h0000_0020);
    $display("watchdog test done");

    // on two ticks, off one tick; the first on phase is skipped
    wr(`FEC_A_TIMER, 32'h0001_0002);
    wr(`FEC_A_CTRL, 32'h0000_0010);
    for (n = 0; n < 200 && cyc_out !== 1'b1; n++) @(posedge aclk);
    for (n = 0; n < 200 && cyc_out === 1'b1; n++) @(posedge aclk);
    for (n = 0; n < 200 && cyc_out === 1'b0; n++) @(posedge aclk);
    chk(n, 32'd10);
    for (n = 0; n < 200 && cyc_out === 1'b1; n++) @(posedge aclk);
    chk(n, 32'd20);
    $display("cyclic timer test done");
    complete_run();
  end
endmodule
